// file: rtl/iepb_pkg.sv
// Purpose: Constants and carrier types for the interrupt enable and priority bank
// Assumes: 32-bit AHB-Lite data, 16-bit registers in the low half of each word
// Notes: Offsets are byte addresses
package iepb_pkg;
  localparam logic [7:0] IEPB_OFF_EN4 = 8'h00;
  localparam logic [7:0] IEPB_OFF_EN5 = 8'h04;
  localparam logic [7:0] IEPB_OFF_PR0 = 8'h08;
  localparam logic [7:0] IEPB_OFF_PR1 = 8'h0c;
  localparam logic [7:0] IEPB_OFF_PR2 = 8'h10;
  localparam logic [7:0] IEPB_OFF_PR3 = 8'h14;
  localparam int IEPB_NUM_PR = 4;
  // Writable masks; all other bits read zero
  localparam logic [15:0] IEPB_MASK_EN4 = 16'h210e;
  localparam logic [15:0] IEPB_MASK_EN5 = 16'h3ffe;
  localparam logic [15:0] IEPB_MASK_PR0 = 16'h7777;
  localparam logic [15:0] IEPB_MASK_PR1 = 16'h7770;
  localparam logic [15:0] IEPB_MASK_PR2 = 16'h7777;
  localparam logic [15:0] IEPB_MASK_PR3 = 16'h0077;
  localparam logic [15:0] IEPB_RST_EN = 16'h0000;
  localparam logic [15:0] IEPB_RST_PR_ALL = 16'h4444;
  localparam logic [2:0] IEPB_PRI_OFF = 3'h0;
  // Enable bit positions
  localparam int IEPB_B_CHARGE = 13;
  localparam int IEPB_B_LVD = 8;
  localparam int IEPB_B_CRC = 3;
  localparam int IEPB_B_U2ERR = 2;
  localparam int IEPB_B_U1ERR = 1;
  localparam int IEPB_B_CAP9 = 13;
  localparam int IEPB_B_CMP9 = 12;
  localparam int IEPB_B_SPI3EV = 11;
  localparam int IEPB_B_SPI3FT = 10;
  localparam int IEPB_B_U4TX = 9;
  localparam int IEPB_B_U4RX = 8;
  localparam int IEPB_B_U4ERR = 7;
  localparam int IEPB_B_USB = 6;
  localparam int IEPB_B_I2C3M = 5;
  localparam int IEPB_B_I2C3S = 4;
  localparam int IEPB_B_U3TX = 3;
  localparam int IEPB_B_U3RX = 2;
  localparam int IEPB_B_U3ERR = 1;
  // Priority field low bit positions
  localparam int IEPB_F_HI = 12;
  localparam int IEPB_F_MH = 8;
  localparam int IEPB_F_ML = 4;
  localparam int IEPB_F_LO = 0;

  typedef struct packed {
    logic charge_time_irq_enable;
    logic low_voltage_irq_enable;
    logic crc_gen_irq_enable;
    logic uart2_error_irq_enable;
    logic uart1_error_irq_enable;
    logic capture9_irq_enable;
    logic compare9_irq_enable;
    logic spi3_event_irq_enable;
    logic spi3_fault_irq_enable;
    logic uart4_tx_irq_enable;
    logic uart4_rx_irq_enable;
    logic uart4_error_irq_enable;
    logic usb_irq_enable;
    logic i2c3_master_irq_enable;
    logic i2c3_slave_irq_enable;
    logic uart3_tx_irq_enable;
    logic uart3_rx_irq_enable;
    logic uart3_error_irq_enable;
  } iepb_enable_type;

  typedef struct packed {
    logic [2:0] timer1_priority;
    logic [2:0] compare1_priority;
    logic [2:0] capture1_priority;
    logic [2:0] ext_irq0_priority;
    logic [2:0] timer2_priority;
    logic [2:0] compare2_priority;
    logic [2:0] capture2_priority;
    logic [2:0] uart1_rx_priority;
    logic [2:0] spi1_event_priority;
    logic [2:0] spi1_fault_priority;
    logic [2:0] timer3_priority;
    logic [2:0] adc_done_priority;
    logic [2:0] uart1_tx_priority;
  } iepb_priority_type;
endpackage

// file: rtl/iepb_pri_gate.sv
// Purpose: Gates one raw request by its enable bit and priority field
// Assumes: Priority field comes straight from a register
// Notes: Level 0 means the source is off
`timescale 1ns/1ps
`default_nettype none
module iepb_pri_gate
  import iepb_pkg::*;
(
  // Source
  input wire logic req,
  input wire logic enable,
  input wire logic [2:0] prio,
  // Result
  output logic active,
  output logic [2:0] level
);
  // Level maps straight from the field: 001 is 1, 111 is 7
  assign level = prio;
  // Off field beats a set enable
  assign active = req && enable && (prio != IEPB_PRI_OFF);
endmodule // iepb_pri_gate
`default_nettype wire

// file: rtl/iepb_bank.sv
// Purpose: Interrupt enable and priority register bank on AHB-Lite
// Assumes: Single-word transfers; zero-wait-state slave, OKAY always
// Notes: Outputs are registered; gated requests go to the arbiter
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module iepb_bank
  import iepb_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Raw requests, same clock, order as the priority struct
  input wire logic [12:0] raw_req,
  // To arbitration
  output iepb_enable_type enables,
  output iepb_priority_type priorities,
  output logic [12:0] req_active,
  output logic [38:0] req_level
);
  logic [15:0] en4_q, en4_d, en5_q, en5_d;
  logic [15:0] pr_q [IEPB_NUM_PR];
  logic [15:0] pr_d [IEPB_NUM_PR];
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [12:0] act_q;
  logic [38:0] lvl_q;
  logic [12:0] act_c;
  logic [38:0] lvl_c;
  logic [38:0] pri_flat;
  logic [12:0] en_per_pri;
  logic take;

  function automatic logic [15:0] pr_mask(input int idx);
    case (idx)
      0: pr_mask = IEPB_MASK_PR0;
      1: pr_mask = IEPB_MASK_PR1;
      2: pr_mask = IEPB_MASK_PR2;
      default: pr_mask = IEPB_MASK_PR3;
    endcase
  endfunction

  function automatic logic [15:0] rd_word(input logic [7:0] a, input logic [15:0] e4,
    input logic [15:0] e5, input logic [15:0] p0, input logic [15:0] p1,
    input logic [15:0] p2, input logic [15:0] p3);
    case (a)
      IEPB_OFF_EN4: rd_word = e4;
      IEPB_OFF_EN5: rd_word = e5;
      IEPB_OFF_PR0: rd_word = p0;
      IEPB_OFF_PR1: rd_word = p1;
      IEPB_OFF_PR2: rd_word = p2;
      IEPB_OFF_PR3: rd_word = p3;
      default: rd_word = 16'h0000;
    endcase
  endfunction

  assign take = hsel && hready && htrans[1];

  // Register file next state; writes land the edge after the data phase
  always_comb
  begin
    en4_d = en4_q;
    en5_d = en5_q;
    pr_d = pr_q;
    wr_pend_d = take && hwrite;
    wr_addr_d = haddr[7:0];
    rdata_d = rdata_q;
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        IEPB_OFF_EN4: en4_d = hwdata[15:0] & IEPB_MASK_EN4;
        IEPB_OFF_EN5: en5_d = hwdata[15:0] & IEPB_MASK_EN5;
        IEPB_OFF_PR0: pr_d[0] = hwdata[15:0] & pr_mask(0);
        IEPB_OFF_PR1: pr_d[1] = hwdata[15:0] & pr_mask(1);
        IEPB_OFF_PR2: pr_d[2] = hwdata[15:0] & pr_mask(2);
        IEPB_OFF_PR3: pr_d[3] = hwdata[15:0] & pr_mask(3);
        default: ;
      endcase
    end
    // Read sees the value after any write pending in this cycle
    if (take && !hwrite)
    begin
      rdata_d = {16'h0000, rd_word(haddr[7:0], en4_d, en5_d, pr_d[0], pr_d[1],
        pr_d[2], pr_d[3])};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en4_q <= IEPB_RST_EN;
      en5_q <= IEPB_RST_EN;
      for (int i = 0; i < IEPB_NUM_PR; i++)
      begin
        pr_q[i] <= IEPB_RST_PR_ALL & pr_mask(i);
      end
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      en4_q <= en4_d;
      en5_q <= en5_d;
      pr_q <= pr_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // Zero wait states: hready_out and response come from flops; hready_out is low in reset, then always 1
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = rdata_q;

  a_en4_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == IEPB_OFF_EN4) |=>
      (en4_q == ($past(hwdata[15:0]) & IEPB_MASK_EN4)))
    else $error("Enable 4 write lost");
  a_pr0_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == IEPB_OFF_PR0) |=>
      (pr_q[0] == ($past(hwdata[15:0]) & IEPB_MASK_PR0)))
    else $error("Priority 0 write lost");
  a_pr1_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == IEPB_OFF_PR1) |=>
      (pr_q[1] == ($past(hwdata[15:0]) & IEPB_MASK_PR1)))
    else $error("Priority 1 write lost");
  a_pr2_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == IEPB_OFF_PR2) |=>
      (pr_q[2] == ($past(hwdata[15:0]) & IEPB_MASK_PR2)))
    else $error("Priority 2 write lost");
  a_pr3_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == IEPB_OFF_PR3) |=>
      (pr_q[3] == ($past(hwdata[15:0]) & IEPB_MASK_PR3)))
    else $error("Priority 3 write lost");
  a_hold_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pend_q |=> $stable(en4_q) && $stable(en5_q) && $stable(pr_q[0]) && $stable(pr_q[3]))
    else $error("Register changed without write");
  a_read_en4: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && (haddr[7:0] == IEPB_OFF_EN4) && !wr_pend_q |=>
      (hrdata == {16'h0000, en4_q}))
    else $error("Enable read mismatch");
  a_read_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && (haddr[7:0] > IEPB_OFF_PR3) |=> (hrdata == 32'h0000_0000))
    else $error("Unmapped read not zero");

  // Field placement into the carrier
  assign enables = '{
    charge_time_irq_enable: en4_q[IEPB_B_CHARGE],
    low_voltage_irq_enable: en4_q[IEPB_B_LVD],
    crc_gen_irq_enable: en4_q[IEPB_B_CRC],
    uart2_error_irq_enable: en4_q[IEPB_B_U2ERR],
    uart1_error_irq_enable: en4_q[IEPB_B_U1ERR],
    capture9_irq_enable: en5_q[IEPB_B_CAP9],
    compare9_irq_enable: en5_q[IEPB_B_CMP9],
    spi3_event_irq_enable: en5_q[IEPB_B_SPI3EV],
    spi3_fault_irq_enable: en5_q[IEPB_B_SPI3FT],
    uart4_tx_irq_enable: en5_q[IEPB_B_U4TX],
    uart4_rx_irq_enable: en5_q[IEPB_B_U4RX],
    uart4_error_irq_enable: en5_q[IEPB_B_U4ERR],
    usb_irq_enable: en5_q[IEPB_B_USB],
    i2c3_master_irq_enable: en5_q[IEPB_B_I2C3M],
    i2c3_slave_irq_enable: en5_q[IEPB_B_I2C3S],
    uart3_tx_irq_enable: en5_q[IEPB_B_U3TX],
    uart3_rx_irq_enable: en5_q[IEPB_B_U3RX],
    uart3_error_irq_enable: en5_q[IEPB_B_U3ERR]
  };

  assign priorities = '{
    timer1_priority: pr_q[0][IEPB_F_HI +: 3],
    compare1_priority: pr_q[0][IEPB_F_MH +: 3],
    capture1_priority: pr_q[0][IEPB_F_ML +: 3],
    ext_irq0_priority: pr_q[0][IEPB_F_LO +: 3],
    timer2_priority: pr_q[1][IEPB_F_HI +: 3],
    compare2_priority: pr_q[1][IEPB_F_MH +: 3],
    capture2_priority: pr_q[1][IEPB_F_ML +: 3],
    uart1_rx_priority: pr_q[2][IEPB_F_HI +: 3],
    spi1_event_priority: pr_q[2][IEPB_F_MH +: 3],
    spi1_fault_priority: pr_q[2][IEPB_F_ML +: 3],
    timer3_priority: pr_q[2][IEPB_F_LO +: 3],
    adc_done_priority: pr_q[3][IEPB_F_ML +: 3],
    uart1_tx_priority: pr_q[3][IEPB_F_LO +: 3]
  };

  a_en5_map: assert property (@(posedge hclk) disable iff (!hresetn)
    (enables.capture9_irq_enable == en5_q[13]) && (enables.spi3_fault_irq_enable == en5_q[10])
      && (enables.usb_irq_enable == en5_q[6]) && (enables.uart3_error_irq_enable == en5_q[1]))
    else $error("Enable 5 map wrong");
  a_pr_map: assert property (@(posedge hclk) disable iff (!hresetn)
    (priorities.timer1_priority == pr_q[0][14:12])
      && (priorities.ext_irq0_priority == pr_q[0][2:0])
      && (priorities.capture2_priority == pr_q[1][6:4])
      && (priorities.timer3_priority == pr_q[2][2:0])
      && (priorities.adc_done_priority == pr_q[3][6:4]))
    else $error("Priority map wrong");

  // Prioritised sources have no enable bit in this bank; enables live elsewhere
  assign en_per_pri = '1;
  assign pri_flat = priorities;

  generate
    for (genvar g = 0; g < 13; g++)
    begin : g_gate
      iepb_pri_gate u_gate (
        .req(raw_req[g]),
        .enable(en_per_pri[g]),
        .prio(pri_flat[g*3 +: 3]),
        .active(act_c[g]),
        .level(lvl_c[g*3 +: 3])
      );
    end
  endgenerate

  // Registered so every output leaves a flop; costs one cycle of request latency
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_q <= 13'h0000;
      lvl_q <= 39'h00_0000_0000;
    end
    else
    begin
      act_q <= act_c;
      lvl_q <= lvl_c;
    end
  end
  assign req_active = act_q;
  assign req_level = lvl_q;

  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ((en4_q & ~IEPB_MASK_EN4) == 16'h0000) && ((pr_q[3] & ~IEPB_MASK_PR3) == 16'h0000))
    else $error("Unimplemented bit set");
  a_reserved_rest: assert property (@(posedge hclk) disable iff (!hresetn)
    ((en5_q & ~IEPB_MASK_EN5) == 16'h0000) && ((pr_q[0] & ~IEPB_MASK_PR0) == 16'h0000)
      && ((pr_q[1] & ~IEPB_MASK_PR1) == 16'h0000) && ((pr_q[2] & ~IEPB_MASK_PR2) == 16'h0000))
    else $error("Unimplemented priority bit set");
  a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && (wr_addr_q == IEPB_OFF_EN5) |=>
      (en5_q == ($past(hwdata[15:0]) & IEPB_MASK_EN5)))
    else $error("Enable write not applied");
  a_off_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    (pri_flat[2:0] == IEPB_PRI_OFF) |=> !act_q[0])
    else $error("Disabled source active");
  a_gate_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !raw_req[5] |=> !act_q[5])
    else $error("Quiet source active");
  a_level_passes: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_req[12] && (pri_flat[38:36] != IEPB_PRI_OFF) |=>
      act_q[12] && (lvl_q[38:36] == $past(pri_flat[38:36])))
    else $error("Active level wrong");
  // Gated on the previous reset level so the reset-cleared levels are not compared
  a_level_all: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> (lvl_q == $past(pri_flat)))
    else $error("Level does not follow field");
  a_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && (haddr[7:0] == IEPB_OFF_PR1) && !wr_pend_q |=>
      (hrdata == {16'h0000, pr_q[1]}))
    else $error("Read data mismatch");
  a_pr1_nibble: assert property (@(posedge hclk) disable iff (!hresetn)
    (pr_q[1][3:0] == 4'h0) && (pr_q[0][15] == 1'b0) && (pr_q[2][11] == 1'b0))
    else $error("Priority gap bit set");
  a_en4_map: assert property (@(posedge hclk) disable iff (!hresetn)
    enables.low_voltage_irq_enable == en4_q[8] && enables.charge_time_irq_enable == en4_q[13])
    else $error("Enable map wrong");
  a_reset_pri: assert property (@(posedge hclk)
    $rose(hresetn) |-> (pr_q[2] == 16'h4444) && (en5_q == 16'h0000))
    else $error("Reset value wrong");
  a_reset_rest: assert property (@(posedge hclk)
    $rose(hresetn) |-> (en4_q == 16'h0000) && (pr_q[0] == 16'h4444) && (pr_q[1] == 16'h4440)
      && (pr_q[3] == 16'h0044))
    else $error("Reset value of other registers wrong");
endmodule // iepb_bank
`default_nettype wire

// file: test/test_irq_enable_priority_bank.sv
// Purpose: Self-checking bench for the interrupt enable and priority bank
// Assumes: Zero-wait AHB-Lite slave, each register in bits 15:0 of its word
// Notes: Gated request outputs lag the registers by one cycle
`timescale 1ns/1ps
`default_nettype none
module test_irq_enable_priority_bank
  import iepb_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [12:0] raw_req, req_active;
  logic [38:0] req_level;
  iepb_enable_type enables;
  iepb_priority_type priorities;
  int n_mismatch, check_count;
  // Last entry is an unmapped word
  localparam logic [7:0] ADR [7] = '{IEPB_OFF_EN4, IEPB_OFF_EN5, IEPB_OFF_PR0, IEPB_OFF_PR1,
    IEPB_OFF_PR2, IEPB_OFF_PR3, 8'h18};
  localparam logic [31:0] RST [7] = '{32'h0, 32'h0, 32'h4444, 32'h4440, 32'h4444, 32'h44, 32'h0};
  localparam logic [31:0] MSK [7] = '{32'h210e, 32'h3ffe, 32'h7777, 32'h7770, 32'h7777, 32'h77,
    32'h0};
  localparam int B4 [5] = '{13, 8, 3, 2, 1};

  iepb_bank i_iepb_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .raw_req(raw_req),
    .enables(enables), .priorities(priorities), .req_active(req_active),
    .req_level(req_level));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic tally_and_finish;
    $display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [38:0] seen, input logic [38:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Bounded so a stuck slave ends the run instead of hanging it
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1)
    begin
      n_mismatch++;
      $display("ERROR t=%0t hreadyout never came", $time);
      tally_and_finish;
    end
  endtask

  // One idle edge first so no signal is driven twice in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  task automatic t_reset;
    check(enables, 39'h0, "reset enables");
    check(priorities, {13{3'h4}}, "reset fields");
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, ADR[i], 32'h0);
      check(rd, RST[i], "reset read");
    end
    check({hreadyout, hresp}, 2'b10, "bus status");
    $display("test reset done");
  endtask

  task automatic t_mask;
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, ADR[i], 32'hffffffff);
      bus(1'b0, ADR[i], 32'h0);
      check(rd, MSK[i], "masked readback");
      bus(1'b1, ADR[i], 32'h0);
    end
    $display("test mask done");
  endtask

  task automatic t_enables;
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, IEPB_OFF_EN4, 32'h1 << B4[i]);
      @(negedge hclk);
      check(enables, 18'h1 << (17 - i), "enable 4 bit");
    end
    bus(1'b1, IEPB_OFF_EN4, 32'h0);
    for (int b = 1; b < 14; b++)
    begin
      bus(1'b1, IEPB_OFF_EN5, 32'h1 << b);
      @(negedge hclk);
      check(enables, 18'h1 << (b - 1), "enable 5 bit");
    end
    bus(1'b1, IEPB_OFF_EN5, 32'h0);
    $display("test enables done");
  endtask

  task automatic t_prio;
    @(posedge hclk);
    raw_req <= '1;
    bus(1'b1, IEPB_OFF_PR0, 32'h7123);
    bus(1'b1, IEPB_OFF_PR1, 32'h5670);
    bus(1'b1, IEPB_OFF_PR2, 32'h1234);
    bus(1'b1, IEPB_OFF_PR3, 32'h65);
    @(negedge hclk);
    check(priorities, {12'he53, 9'h177, 12'h29c, 6'h35}, "fields");
    bus(1'b1, IEPB_OFF_PR0, 32'h0170);
    repeat (2) @(negedge hclk);
    check(req_active, 13'h0dff, "gated requests");
    check(req_level, {12'h078, 9'h177, 12'h29c, 6'h35}, "levels");
    for (int v = 1; v < 8; v++)
    begin
      bus(1'b1, IEPB_OFF_PR3, (v << 4) | (7 - v));
      repeat (2) @(negedge hclk);
      check(req_level[5:0], {3'(v), 3'(7 - v)}, "linear level");
      check(req_active[1:0], {1'b1, v != 7}, "zero field off");
    end
    @(posedge hclk);
    raw_req <= '0;
    repeat (2) @(negedge hclk);
    check(req_active, 39'h0, "requests dropped");
    $display("test priorities done");
  endtask

  task automatic t_midreset;
    bus(1'b1, IEPB_OFF_EN5, 32'h3ffe);
    bus(1'b1, IEPB_OFF_PR2, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    check(enables, 39'h0, "midrun enables");
    check(priorities, {13{3'h4}}, "midrun fields");
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, IEPB_OFF_EN5, 32'h0);
    check(rd, 32'h0, "midrun enable read");
    bus(1'b0, IEPB_OFF_PR2, 32'h0);
    check(rd, 32'h4444, "midrun field read");
    $display("test midrun reset done");
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    raw_req = 13'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_mask;
    t_enables;
    t_prio;
    t_midreset;
    tally_and_finish;
  end
endmodule // test_irq_enable_priority_bank
`default_nettype wire
